// >>> verilog/rtm_output_trim.sv
`timescale 1ns/100ps
// Contract
// - Pin carries square wave, alarm interrupt or general level, chosen by enables.
// - Square-wave enable set: square wave on the pin, alarm enables ignored.
// - Square wave off and any alarm enabled: pin is alarm interrupt output.
// - All three enables off: pin follows the general-purpose level bit.
// - One alarm: pin equals its flag, inverted when polarity is zero.
// - Two alarms: OR of flags at polarity one, NAND at polarity zero.
// - Frequency select: 00 1 Hz, 01 4.096k, 10 8.192k, 11 32.768k.
// - Coarse trim with square wave on gives trimmed 64 Hz, select ignored.
// - All square-wave rates are trimmed except the raw 32.768 kHz.
// - Without coarse trim, the adjustment happens automatically once per minute.
// - Sign one adds cycles, sign zero removes cycles.
// - Each magnitude step is two oscillator cycles, up to 254.
// - Zero magnitude disables trimming whatever the sign.
// - Coarse trim repeats the same adjustment 128 times per second.
// - External clock bit selects the oscillator input pin; otherwise it is ignored.
// - Pin is only pulled low or released, never driven high.
// - Alarm flag set by match only; weekday write clears, match re-sets it.
module rtm_output_trim
  import rtm_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Oscillator sources
  input wire logic oscillator_start_bit,
  input wire logic crystal_clk,
  input wire logic oscillator_input_pin,
  // Alarm comparators
  input wire logic alarm0_match,
  input wire logic alarm1_match,
  // Multi-function pin, open drain
  input wire logic multi_function_pin_i,
  output logic multi_function_pin_o,
  output logic multi_function_pin_oe,
  // Timebase
  output logic second_tick
);

  typedef struct packed {
    logic [7:0] control;
    logic [7:0] trim;
    logic alarm_output_polarity;
    logic [7:0] rdata;
    logic osc_prev;
    logic [RTM_PRE_W-1:0] pre;
    logic [5:0] sec;
    logic [7:0] pending;
    logic pending_add;
    logic pin_oe;
    logic sec_tick;
  } rtm_state_type;

  rtm_state_type s_q;
  rtm_state_type s_d;

  logic wr_alm0;
  logic wr_alm1;
  logic alarm0_flag;
  logic alarm1_flag;
  logic [6:0] wk0_bits;
  logic [6:0] wk1_bits;

  assign wr_alm0 = reg_wr && (reg_addr == RTM_ADDR_ALM0_WKDAY);
  assign wr_alm1 = reg_wr && (reg_addr == RTM_ADDR_ALM1_WKDAY);

  // ==========================================================================
  // Alarm flags
  rtm_alarm_flag u_alarm0 (
    .clk_sys(clk_sys),
    .rst(rst),
    .wr_en(wr_alm0),
    .wdata(reg_wdata[6:0]),
    .match(alarm0_match),
    .wkday_bits(wk0_bits),
    .flag(alarm0_flag)
  );

  rtm_alarm_flag u_alarm1 (
    .clk_sys(clk_sys),
    .rst(rst),
    .wr_en(wr_alm1),
    .wdata(reg_wdata[6:0]),
    .match(alarm1_match),
    .wkday_bits(wk1_bits),
    .flag(alarm1_flag)
  );

  // ==========================================================================
  // Next state
  always_comb begin
    logic osc_level;
    logic osc_tick;
    logic [1:0] adv;
    logic [RTM_PRE_W:0] sum;
    logic sec_wrap;
    logic adjust_evt;
    logic sqw_level;
    logic level;
    logic sqw_en;
    logic a0_en;
    logic a1_en;
    logic pol;
    osc_level = 1'b0;
    osc_tick = 1'b0;
    adv = 2'h0;
    sum = '0;
    sec_wrap = 1'b0;
    adjust_evt = 1'b0;
    sqw_level = 1'b0;
    level = 1'b0;
    sqw_en = s_q.control[RTM_CTL_SQW_EN];
    a0_en = s_q.control[RTM_CTL_ALM0_EN];
    a1_en = s_q.control[RTM_CTL_ALM1_EN];
    pol = s_q.alarm_output_polarity;
    s_d = s_q;

    // Register writes.
    if (reg_wr) begin
      if (reg_addr == RTM_ADDR_CONTROL) begin
        s_d.control = reg_wdata;
      end
      if (reg_addr == RTM_ADDR_TRIM) begin
        s_d.trim = reg_wdata;
      end
      // The polarity bit is one latch shared by both weekday registers.
      if (wr_alm0 || wr_alm1) begin
        s_d.alarm_output_polarity = reg_wdata[RTM_WK_POL];
      end
    end

    // Register reads; unmapped addresses read as zero.
    if (reg_rd) begin
      unique case (reg_addr)
        RTM_ADDR_CONTROL: s_d.rdata = s_q.control;
        RTM_ADDR_TRIM: s_d.rdata = s_q.trim;
        RTM_ADDR_ALM0_WKDAY: s_d.rdata = {pol, wk0_bits};
        RTM_ADDR_ALM1_WKDAY: s_d.rdata = {pol, wk1_bits};
        default: s_d.rdata = 8'h00;
      endcase
    end

    // Oscillator source and edge detect.
    if (s_q.control[RTM_CTL_EXT_CLK]) begin
      osc_level = oscillator_input_pin;
    end else begin
      osc_level = oscillator_start_bit & crystal_clk;
    end
    s_d.osc_prev = osc_level;
    osc_tick = osc_level && !s_q.osc_prev;

    // Trimmed timebase: a pending correction either inserts or swallows ticks.
    if (osc_tick) begin
      if (s_q.pending != 8'h00) begin
        s_d.pending = s_q.pending - 8'h01;
        adv = s_q.pending_add ? 2'h2 : 2'h0;
      end else begin
        adv = 2'h1;
      end
    end
    sum = {1'b0, s_q.pre} + {{(RTM_PRE_W - 1){1'b0}}, adv};
    s_d.pre = sum[RTM_PRE_W-1:0];
    sec_wrap = sum[RTM_PRE_W];
    s_d.sec_tick = sec_wrap;
    if (sec_wrap) begin
      s_d.sec = (s_q.sec == RTM_SEC_LAST) ? 6'h00 : s_q.sec + 6'h01;
    end

    if (s_q.control[RTM_CTL_COARSE]) begin
      adjust_evt = sum[RTM_PRE_W:RTM_COARSE_BIT] !=
                   {1'b0, s_q.pre[RTM_PRE_W-1:RTM_COARSE_BIT]};
    end else begin
      adjust_evt = sec_wrap && (s_q.sec == RTM_SEC_LAST);
    end
    if (adjust_evt && (s_q.trim[6:0] != 7'h00)) begin
      s_d.pending = {s_q.trim[6:0], 1'b0};
      s_d.pending_add = s_q.trim[RTM_TRIM_SIGN];
    end

    // Square-wave source.
    if (s_q.control[RTM_CTL_COARSE]) begin
      sqw_level = s_q.pre[RTM_TAP_64HZ];
    end else begin
      unique case (s_q.control[RTM_CTL_FS_HI:RTM_CTL_FS_LO])
        RTM_FS_1HZ: sqw_level = s_q.pre[RTM_TAP_1HZ];
        RTM_FS_4K096: sqw_level = s_q.pre[RTM_TAP_4K096];
        RTM_FS_8K192: sqw_level = s_q.pre[RTM_TAP_8K192];
        RTM_FS_32K768: sqw_level = osc_level;
      endcase
    end

    // Output mode selection, evaluated every system clock.
    if (sqw_en) begin
      level = sqw_level;
    end else if (a0_en && a1_en) begin
      level = pol ? (alarm0_flag | alarm1_flag) : ~(alarm0_flag & alarm1_flag);
    end else if (a0_en) begin
      level = pol ? alarm0_flag : ~alarm0_flag;
    end else if (a1_en) begin
      level = pol ? alarm1_flag : ~alarm1_flag;
    end else begin
      level = s_q.control[RTM_CTL_LEVEL];
    end
    // Low is pulled, high is released to the pull-up.
    s_d.pin_oe = ~level;
  end

  // ==========================================================================
  // State register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_q.control <= RTM_RST_CONTROL;
      s_q.trim <= RTM_RST_TRIM;
      s_q.alarm_output_polarity <= 1'b0;
      s_q.rdata <= 8'h00;
      s_q.osc_prev <= 1'b0;
      s_q.pre <= '0;
      s_q.sec <= 6'h00;
      s_q.pending <= 8'h00;
      s_q.pending_add <= 1'b0;
      s_q.pin_oe <= 1'b0;
      s_q.sec_tick <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;
  assign multi_function_pin_o = 1'b0;
  assign multi_function_pin_oe = s_q.pin_oe;
  assign second_tick = s_q.sec_tick;

endmodule : rtm_output_trim

// >>> verilog/rtm_pkg.sv
package rtm_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] RTM_ADDR_CONTROL = 8'h07;
  localparam logic [7:0] RTM_ADDR_TRIM = 8'h08;
  localparam logic [7:0] RTM_ADDR_ALM0_WKDAY = 8'h0d;
  localparam logic [7:0] RTM_ADDR_ALM1_WKDAY = 8'h14;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] RTM_RST_CONTROL = 8'h80;
  localparam logic [7:0] RTM_RST_TRIM = 8'h00;
  localparam logic [7:0] RTM_RST_WKDAY = 8'h01;

  // ==========================================================================
  // Control register fields
  localparam int RTM_CTL_LEVEL = 7;
  localparam int RTM_CTL_SQW_EN = 6;
  localparam int RTM_CTL_ALM1_EN = 5;
  localparam int RTM_CTL_ALM0_EN = 4;
  localparam int RTM_CTL_EXT_CLK = 3;
  localparam int RTM_CTL_COARSE = 2;
  localparam int RTM_CTL_FS_HI = 1;
  localparam int RTM_CTL_FS_LO = 0;

  // ==========================================================================
  // Trim and weekday fields
  localparam int RTM_TRIM_SIGN = 7;
  localparam int RTM_WK_POL = 7;
  localparam int RTM_WK_FLAG = 3;

  // ==========================================================================
  // Frequency select codes
  localparam logic [1:0] RTM_FS_1HZ = 2'h0;
  localparam logic [1:0] RTM_FS_4K096 = 2'h1;
  localparam logic [1:0] RTM_FS_8K192 = 2'h2;
  localparam logic [1:0] RTM_FS_32K768 = 2'h3;

  // ==========================================================================
  // Timebase: 15-bit prescaler of the 32.768 kHz oscillator, tap positions
  localparam int RTM_PRE_W = 15;
  localparam int RTM_TAP_8K192 = 1;
  localparam int RTM_TAP_4K096 = 2;
  localparam int RTM_COARSE_BIT = 8;
  localparam int RTM_TAP_64HZ = 8;
  localparam int RTM_TAP_1HZ = 14;
  localparam logic [5:0] RTM_SEC_LAST = 6'h3b;

endpackage : rtm_pkg

// >>> verilog/rtm_alarm_flag.sv
`timescale 1ns/100ps
module rtm_alarm_flag
  import rtm_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Register access
  input wire logic wr_en,
  input wire logic [6:0] wdata,
  // Alarm comparator
  input wire logic match,
  // State
  output logic [6:0] wkday_bits,
  output logic flag
);

  typedef struct packed {
    logic [6:0] bits;
  } rtm_flag_state_type;

  rtm_flag_state_type s_q;
  rtm_flag_state_type s_d;

  // ==========================================================================
  // Next state
  always_comb begin
    s_d = s_q;
    if (wr_en) begin
      s_d.bits = wdata;
      s_d.bits[RTM_WK_FLAG] = 1'b0;
    end
    // A match in the same cycle as the clearing write still sets the flag.
    if (match) begin
      s_d.bits[RTM_WK_FLAG] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_q.bits <= RTM_RST_WKDAY[6:0];
    end else begin
      s_q <= s_d;
    end
  end

  assign wkday_bits = s_q.bits;
  assign flag = s_q.bits[RTM_WK_FLAG];

endmodule : rtm_alarm_flag

// >>> bench/rtm_output_trim_props.sv
`timescale 1ns/100ps
module rtm_output_trim_props
  import rtm_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // Sources and pin
  input wire logic oscillator_start_bit,
  input wire logic alarm0_match,
  input wire logic alarm1_match,
  input wire logic multi_function_pin_o,
  input wire logic multi_function_pin_oe
);
  // ==========================================================================
  // Shadow state
  logic [7:0] ctl_q, trim_q, exp_rd;
  logic [6:0] wk0_q, wk1_q;
  logic pol_q, f0_q, f1_q, lvl;
  wire logic w0 = reg_wr && reg_addr == RTM_ADDR_ALM0_WKDAY;
  wire logic w1 = reg_wr && reg_addr == RTM_ADDR_ALM1_WKDAY;
  wire logic no_src = ctl_q[6] && !oscillator_start_bit && !ctl_q[3];
  wire logic sq32 = ctl_q[6] && !ctl_q[2] && ctl_q[1:0] == RTM_FS_32K768;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctl_q <= RTM_RST_CONTROL;
      trim_q <= RTM_RST_TRIM;
      wk0_q <= RTM_RST_WKDAY[6:0];
      wk1_q <= RTM_RST_WKDAY[6:0];
      pol_q <= 1'b0;
      f0_q <= 1'b0;
      f1_q <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == RTM_ADDR_CONTROL) ctl_q <= reg_wdata;
      if (reg_wr && reg_addr == RTM_ADDR_TRIM) trim_q <= reg_wdata;
      if (w0) wk0_q <= reg_wdata[6:0];
      if (w1) wk1_q <= reg_wdata[6:0];
      if (w0 || w1) pol_q <= reg_wdata[7];
      f0_q <= alarm0_match || (f0_q && !w0);
      f1_q <= alarm1_match || (f1_q && !w1);
    end
  end
  always_comb begin
    case (reg_addr)
      RTM_ADDR_CONTROL: exp_rd = ctl_q;
      RTM_ADDR_TRIM: exp_rd = trim_q;
      RTM_ADDR_ALM0_WKDAY: exp_rd = {pol_q, wk0_q[6:4], f0_q, wk0_q[2:0]};
      RTM_ADDR_ALM1_WKDAY: exp_rd = {pol_q, wk1_q[6:4], f1_q, wk1_q[2:0]};
      default: exp_rd = 8'h00;
    endcase
    case (ctl_q[5:4])
      2'h0: lvl = ctl_q[7];
      2'h1: lvl = f0_q ~^ pol_q;
      2'h2: lvl = f1_q ~^ pol_q;
      default: lvl = pol_q ? f0_q || f1_q : !(f0_q && f1_q);
    endcase
  end
  // ==========================================================================
  // Properties
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_alm0_hit;
    ctl_q[6:4] == 3'h1 && !pol_q && alarm0_match && !reg_wr;
  endsequence
  // A source switch may legally glitch the raw clock once, so it must have settled first.
  sequence s_raw_steady;
    sq32 && $stable(ctl_q) && $stable(oscillator_start_bit);
  endsequence
  pin_release_a: assert property (multi_function_pin_o == 1'b0)
    else $error("pin driven high");
  gp_level_a: assert property (ctl_q[6:4] == 3'h0 |=> multi_function_pin_oe == !$past(lvl))
    else $error("general level wrong");
  alarm_mode_a: assert property (!ctl_q[6] && ctl_q[5:4] != 2'h0
    |=> multi_function_pin_oe == !$past(lvl)) else $error("alarm pin wrong");
  alarm_to_pin_a: assert property (s_alm0_hit |-> ##2 multi_function_pin_oe)
    else $error("match not on pin");
  read_back_a: assert property (reg_rd |=> reg_rdata == $past(exp_rd))
    else $error("read data wrong");
  rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved");
  no_source_a: assert property (no_src [*6] |=> $stable(multi_function_pin_oe))
    else $error("pin moved without source");
  sq_raw_a: assert property (s_raw_steady [*4] ##0 $changed(multi_function_pin_oe)
    |=> $stable(multi_function_pin_oe)) else $error("raw clock too fast");
endmodule : rtm_output_trim_props

// >>> bench/rtm_host_pin.sv
`timescale 1ns/100ps
module rtm_host_pin (
  // Clock and counter control
  input wire logic clk_sys,
  input wire logic clr,
  // Open-drain pin
  input wire logic pin_o,
  input wire logic pin_oe,
  output logic pin,
  output int rise_cnt
);
  logic last_q = 1'b1;
  // Only the pull-up can make a high level, so a released pin reads 1.
  assign pin = pin_oe ? pin_o : 1'b1;
  always @(posedge clk_sys) begin
    last_q <= pin;
    if (clr) rise_cnt <= 0;
    else if (pin && !last_q) rise_cnt <= rise_cnt + 1;
  end
endmodule : rtm_host_pin

// >>> bench/rtc_output_mux_and_digital_trim_tb_top.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
  $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module rtc_output_mux_and_digital_trim_tb_top
  import rtm_pkg::*;
();
  logic clk_sys = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, clr = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic start_bit = 1'b1, xtal_on = 1'b1, ext_on = 1'b0, xtal = 1'b0, ext = 1'b0;
  logic alarm0_match = 1'b0, alarm1_match = 1'b0, pin_o, pin_oe, pin, tick;
  logic [1:0] div = 2'h0;
  int rise_cnt, n_mismatch = 0, checks_done = 0, cyc = 0;
  int n_tick = 0;
  int sq_lo[4] = '{0, 63, 127, 511};
  logic [7:0] tv[4] = '{8'h00, 8'h80, 8'hff, 8'h7f};
  int lo[4] = '{3, 3, 6, 1};
  int hi[4] = '{5, 5, 10, 3};
  always #12.5 clk_sys = ~clk_sys;
  // Oscillator levels last two system cycles each, the shortest allowed.
  always @(posedge clk_sys) begin
    div <= div + 2'h1;
    xtal <= xtal_on & div[1];
    ext <= ext_on & div[1];
    cyc <= cyc + 1;
    if (tick === 1'b1) n_tick <= n_tick + 1;
    if (cyc == 60000) begin
      n_mismatch++;
      complete_run();
    end
  end
  rtm_output_trim u_dut (.clk_sys(clk_sys), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .oscillator_start_bit(start_bit), .crystal_clk(xtal), .oscillator_input_pin(ext),
    .alarm0_match(alarm0_match), .alarm1_match(alarm1_match), .multi_function_pin_i(pin),
    .multi_function_pin_o(pin_o), .multi_function_pin_oe(pin_oe), .second_tick(tick));
  rtm_host_pin u_host (.clk_sys(clk_sys), .clr(clr), .pin_o(pin_o), .pin_oe(pin_oe),
    .pin(pin), .rise_cnt(rise_cnt));
  // ==========================================================================
  // Access tasks
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    `CHK("rdata", e, reg_rdata)
  endtask : rchk
  task automatic pinchk(input logic e);
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    `CHK("pin", e, pin)
  endtask : pinchk
  task automatic cnt(input int n, output int c);
    @(posedge clk_sys);
    clr <= 1'b1;
    @(posedge clk_sys);
    clr <= 1'b0;
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
    c = rise_cnt;
  endtask : cnt
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : complete_run
  // ==========================================================================
  // Tests
  initial begin
    int c;
    logic [1:0] en;
    logic pol, f0, f1, x;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    rchk(RTM_ADDR_CONTROL, RTM_RST_CONTROL);
    rchk(RTM_ADDR_TRIM, RTM_RST_TRIM);
    rchk(RTM_ADDR_ALM1_WKDAY, RTM_RST_WKDAY);
    rchk(8'h20, 8'h00);
    `CHK("pin", 1'b1, pin)
    wr(RTM_ADDR_CONTROL, 8'h00);
    pinchk(1'b0);
    $display("test reset_gpio done");
    for (int i = 0; i < 24; i++) begin
      en = 2'(i / 8 + 1);
      {pol, f1, f0} = 3'(i);
      wr(RTM_ADDR_CONTROL, {2'h2, en, 4'h0});
      wr(RTM_ADDR_ALM0_WKDAY, {pol, 7'h09});
      wr(RTM_ADDR_ALM1_WKDAY, {pol, 7'h09});
      alarm0_match <= f0;
      alarm1_match <= f1;
      @(posedge clk_sys);
      alarm0_match <= 1'b0;
      alarm1_match <= 1'b0;
      x = (en == 2'h1) ? f0 : (en == 2'h2) ? f1 : (pol ? f0 | f1 : f0 & f1);
      pinchk(x ~^ pol);
      rchk(RTM_ADDR_ALM0_WKDAY, {pol, 3'h0, f0, 3'h1});
    end
    $display("test alarm_pin done");
    for (int k = 0; k < 4; k++) begin
      wr(RTM_ADDR_CONTROL, 8'h70 | 8'(k));
      cnt(2048, c);
      `CHK("sqw", 1'b1, c >= sq_lo[k] && c <= sq_lo[k] + 2)
    end
    $display("test square_wave done");
    wr(RTM_ADDR_TRIM, 8'h00);
    wr(RTM_ADDR_CONTROL, 8'h47);
    for (int k = 0; k < 4; k++) begin
      wr(RTM_ADDR_TRIM, tv[k]);
      cnt(8192, c);
      `CHK("coarse", 1'b1, c >= lo[k] && c <= hi[k])
    end
    $display("test coarse_trim done");
    start_bit <= 1'b0;
    wr(RTM_ADDR_CONTROL, 8'h43);
    cnt(256, c);
    `CHK("no_source", 0, c)
    xtal_on <= 1'b0;
    ext_on <= 1'b1;
    wr(RTM_ADDR_CONTROL, 8'h4b);
    cnt(256, c);
    `CHK("external", 1'b1, c >= 63 && c <= 65)
    $display("test external_clock done");
    // The whole run covers far fewer than one second of oscillator counts.
    `CHK("second_tick", 0, n_tick)
    complete_run();
  end
endmodule : rtc_output_mux_and_digital_trim_tb_top
bind rtm_output_trim rtm_output_trim_props u_props (.clk_sys(clk_sys), .rst(rst),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .oscillator_start_bit(oscillator_start_bit),
  .alarm0_match(alarm0_match), .alarm1_match(alarm1_match),
  .multi_function_pin_o(multi_function_pin_o), .multi_function_pin_oe(multi_function_pin_oe));
